// File: tlie_enable_bank.sv
// Function
// - Set-enable bit 16 enables debug source
// - Set-enable bits 15..12 enable lines D..A
// - Set-enable bits 11..8 enable converter, radio sources
// - Set-enable bits 7..0 enable security..timer one
// - Zero bits written change no flag
// - Clear-enable ones disable matching sources
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module tlie_enable_bank
	import tlie_pkg::*;
(
	input  wire logic               core_clk_i,
	input  wire logic               sys_rst_i,
	input  wire logic [31:0]        addr_i,
	input  wire logic [31:0]        wdata_i,
	input  wire logic               wr_i,
	input  wire logic               rd_i,
	output logic      [31:0]        rdata_o,
	input  wire logic [NUM_SRC-1:0] src_i,
	output logic      [NUM_SRC-1:0] irq_o
);

	// ********************************************************
	// Decode and write masks
	// ********************************************************
	tlie_bank_if bank_if ();
	tlie_acc_t   acc;
	tlie_flags_t wr_bits;

	always_comb begin
		acc     = tlie_decode(addr_i);
		wr_bits = wdata_i[NUM_SRC-1:0];
		bank_if.set_mask = FLAGS_NONE;
		bank_if.clr_mask = FLAGS_NONE;
		if (wr_i) begin
			case (acc)
				TLIE_ACC_SET: begin
					bank_if.set_mask = wr_bits;
				end
				TLIE_ACC_CLEAR: begin
					bank_if.clr_mask = wr_bits;
				end
				default: begin
					bank_if.set_mask = FLAGS_NONE;
				end
			endcase
		end
	end

	tlie_flag_bank u_bank (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.bus        (bank_if.bank)
	);

	// ********************************************************
	// Read data and gated requests
	// ********************************************************
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	tlie_flags_t irq_reg;
	tlie_flags_t irq_next;

	always_comb begin
		rdata_next = RDATA_IDLE;
		if (rd_i) begin
			case (acc)
				TLIE_ACC_SET, TLIE_ACC_CLEAR: begin
					rdata_next = {{PAD_W{1'h0}}, bank_if.flags};
				end
				default: begin
					rdata_next = RDATA_IDLE;
				end
			endcase
		end
		irq_next = src_i & bank_if.flags;
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_reg <= RDATA_IDLE;
			irq_reg   <= FLAGS_NONE;
		end else begin
			rdata_reg <= rdata_next;
			irq_reg   <= irq_next;
		end
	end

	assign rdata_o = rdata_reg;
	assign irq_o   = irq_reg;

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence set_write_s;
		wr_i && (addr_i == IRQ_ENABLE_SET_ADDR);
	endsequence

	sequence clear_write_s;
		wr_i && (addr_i == IRQ_ENABLE_CLEAR_ADDR);
	endsequence

	sequence reg_read_s;
		rd_i && ((addr_i == IRQ_ENABLE_SET_ADDR) ||
			(addr_i == IRQ_ENABLE_CLEAR_ADDR));
	endsequence

	sequence unmapped_read_s;
		rd_i && (tlie_decode(addr_i) == TLIE_ACC_NONE);
	endsequence

	sequence set_then_read_s;
		set_write_s ##1 reg_read_s;
	endsequence

	sequence clear_then_read_s;
		clear_write_s ##1 reg_read_s;
	endsequence

	sequence reset_done_s;
		$fell(sys_rst_i);
	endsequence

	// ********************************************************
	// Set and clear checks
	// ********************************************************

	debug_set_a : assert property (
		set_write_s ##0 wdata_i[DEBUG_SOURCE]
		|=> bank_if.flags[DEBUG_SOURCE])
		else $error("debug enable not set");

	ext_lines_set_a : assert property (
		set_write_s |=>
		((bank_if.flags[EXT_LINE_D:EXT_LINE_A] &
		$past(wdata_i[EXT_LINE_D:EXT_LINE_A])) ==
		$past(wdata_i[EXT_LINE_D:EXT_LINE_A])))
		else $error("external line enable not set");

	radio_set_a : assert property (
		set_write_s |=>
		((bank_if.flags[CONVERTER_SOURCE:RADIO_TIMER_SOURCE] &
		$past(wdata_i[CONVERTER_SOURCE:RADIO_TIMER_SOURCE])) ==
		$past(wdata_i[CONVERTER_SOURCE:RADIO_TIMER_SOURCE])))
		else $error("converter or radio enable not set");

	low_sources_set_a : assert property (
		set_write_s |=>
		((bank_if.flags[SECURITY_SOURCE:TIMER_ONE_SOURCE] &
		$past(wdata_i[SECURITY_SOURCE:TIMER_ONE_SOURCE])) ==
		$past(wdata_i[SECURITY_SOURCE:TIMER_ONE_SOURCE])))
		else $error("low source enable not set");

	zero_bits_keep_a : assert property (
		(set_write_s or clear_write_s) |=>
		((bank_if.flags & ~$past(wdata_i[NUM_SRC-1:0])) ==
		($past(bank_if.flags) & ~$past(wdata_i[NUM_SRC-1:0]))))
		else $error("zero bit changed an enable");

	clear_ones_a : assert property (
		clear_write_s |=>
		((bank_if.flags & $past(wdata_i[NUM_SRC-1:0])) == FLAGS_NONE))
		else $error("enable not cleared");

	debug_clear_a : assert property (
		clear_write_s ##0 wdata_i[DEBUG_SOURCE]
		|=> !bank_if.flags[DEBUG_SOURCE])
		else $error("debug enable not cleared");

	enable_rise_a : assert property (
		!(wr_i && (addr_i == IRQ_ENABLE_SET_ADDR)) |=>
		((bank_if.flags & ~$past(bank_if.flags)) == FLAGS_NONE))
		else $error("enable turned on without set write");

	enable_fall_a : assert property (
		!(wr_i && (addr_i == IRQ_ENABLE_CLEAR_ADDR)) |=>
		(($past(bank_if.flags) & ~bank_if.flags) == FLAGS_NONE))
		else $error("enable turned off without clear write");

	// ********************************************************
	// Read and hold checks
	// ********************************************************

	read_flags_a : assert property (
		reg_read_s |=>
		(rdata_o == {{PAD_W{1'h0}}, $past(bank_if.flags)}))
		else $error("read data differ from enables");

	upper_bits_zero_a : assert property (
		rdata_o[DATA_W-1:NUM_SRC] == {PAD_W{1'h0}})
		else $error("upper read bits not zero");

	read_idle_a : assert property (
		!rd_i |=> (rdata_o == RDATA_IDLE))
		else $error("read data not idle");

	unmapped_read_a : assert property (
		unmapped_read_s |=> (rdata_o == RDATA_IDLE))
		else $error("unmapped read not zero");

	readback_set_a : assert property (
		set_then_read_s |=>
		((rdata_o[NUM_SRC-1:0] & $past(wdata_i[NUM_SRC-1:0], 2)) ==
		$past(wdata_i[NUM_SRC-1:0], 2)))
		else $error("read after set misses new enables");

	readback_clear_a : assert property (
		clear_then_read_s |=>
		((rdata_o[NUM_SRC-1:0] & $past(wdata_i[NUM_SRC-1:0], 2)) ==
		FLAGS_NONE))
		else $error("read after clear shows old enables");

	no_access_hold_a : assert property (
		!(wr_i && (tlie_decode(addr_i) != TLIE_ACC_NONE)) |=>
		(bank_if.flags == $past(bank_if.flags)))
		else $error("enables changed without write");

	// ********************************************************
	// Request and reset checks
	// ********************************************************

	gated_irq_a : assert property (
		1'h1 |=> (irq_o == ($past(src_i) & $past(bank_if.flags))))
		else $error("request not gated by enable");

	irq_masked_a : assert property (
		1'h1 |=> ((irq_o & ~$past(bank_if.flags)) == FLAGS_NONE))
		else $error("request passed a disabled source");

	reset_clear_a : assert property (
		reset_done_s |->
		((bank_if.flags == ENABLE_RESET) &&
		(rdata_o == RDATA_IDLE) && (irq_o == FLAGS_NONE)))
		else $error("state not cleared by reset");

endmodule
`default_nettype wire

// File: tlie_pkg.sv
`default_nettype none
package tlie_pkg;

	// ********************************************************
	// Sizes
	// ********************************************************
	localparam int unsigned NUM_SRC = 17;
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned PAD_W   = DATA_W - NUM_SRC;

	// ********************************************************
	// Register map
	// ********************************************************
	localparam logic [31:0] IRQ_ENABLE_SET_ADDR   = 32'he000e100;
	localparam logic [31:0] IRQ_ENABLE_CLEAR_ADDR = 32'he000e180;
	localparam logic [16:0] ENABLE_RESET          = 17'h00000;
	localparam logic [31:0] RDATA_IDLE            = 32'h00000000;
	localparam logic [16:0] FLAGS_NONE            = 17'h00000;

	// ********************************************************
	// Source bit positions
	// ********************************************************
	localparam int unsigned TIMER_ONE_SOURCE      = 0;
	localparam int unsigned TIMER_TWO_SOURCE      = 1;
	localparam int unsigned MANAGEMENT_SOURCE     = 2;
	localparam int unsigned BASEBAND_SOURCE       = 3;
	localparam int unsigned SLEEP_TIMER_SOURCE    = 4;
	localparam int unsigned SERIAL_UNIT_ONE_SOURCE = 5;
	localparam int unsigned SERIAL_UNIT_TWO_SOURCE = 6;
	localparam int unsigned SECURITY_SOURCE       = 7;
	localparam int unsigned RADIO_TIMER_SOURCE    = 8;
	localparam int unsigned RADIO_TRANSMIT_SOURCE = 9;
	localparam int unsigned RADIO_RECEIVE_SOURCE  = 10;
	localparam int unsigned CONVERTER_SOURCE      = 11;
	localparam int unsigned EXT_LINE_A            = 12;
	localparam int unsigned EXT_LINE_B            = 13;
	localparam int unsigned EXT_LINE_C            = 14;
	localparam int unsigned EXT_LINE_D            = 15;
	localparam int unsigned DEBUG_SOURCE          = 16;

	// ********************************************************
	// Types
	// ********************************************************
	typedef logic [NUM_SRC-1:0] tlie_flags_t;

	typedef enum {
		TLIE_ACC_NONE,
		TLIE_ACC_SET,
		TLIE_ACC_CLEAR
	} tlie_acc_t;

	// Address decode, shared by write and read paths
	function automatic tlie_acc_t tlie_decode(input logic [31:0] addr);
		tlie_acc_t acc;
		acc = TLIE_ACC_NONE;
		if (addr == IRQ_ENABLE_SET_ADDR) begin
			acc = TLIE_ACC_SET;
		end else if (addr == IRQ_ENABLE_CLEAR_ADDR) begin
			acc = TLIE_ACC_CLEAR;
		end
		return acc;
	endfunction

endpackage
`default_nettype wire

// File: tlie_bank_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tlie_bank_if;
	import tlie_pkg::*;
	tlie_flags_t set_mask;
	tlie_flags_t clr_mask;
	tlie_flags_t flags;

	modport ctrl (output set_mask, output clr_mask, input flags);
	modport bank (input set_mask, input clr_mask, output flags);
endinterface
`default_nettype wire

// File: tlie_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
module tlie_flag_bank
	import tlie_pkg::*;
(
	input  wire logic   core_clk_i,
	input  wire logic   sys_rst_i,
	tlie_bank_if.bank   bus
);

	// ********************************************************
	// Enable flags
	// ********************************************************
	tlie_flags_t flags_reg;
	tlie_flags_t flags_next;

	always_comb begin
		// Ones set or clear, zeros keep
		flags_next = (flags_reg | bus.set_mask) & ~bus.clr_mask;
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			flags_reg <= ENABLE_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign bus.flags = flags_reg;

endmodule
`default_nettype wire

// File: tlie_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module tlie_src_model
	import tlie_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	input  wire tlie_flags_t want_i,
	output tlie_flags_t      src_o
);
	// ****************************************
	// Peripheral request levels
	// ****************************************
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			src_o <= FLAGS_NONE;
		end else begin
			src_o <= want_i;
		end
	end
endmodule
`default_nettype wire

// File: test_top_level_irq_enable_bank.sv
`timescale 1ns/1ps
`default_nettype none
module test_top_level_irq_enable_bank
	import tlie_pkg::*;
;
	localparam logic [31:0] SET_A         = IRQ_ENABLE_SET_ADDR;
	localparam logic [31:0] CLR_A         = IRQ_ENABLE_CLEAR_ADDR;
	localparam logic [31:0] UNMAPPED_ADDR = 32'he000e104;
	logic        clk       = 1'b0;
	logic        rst       = 1'b1;
	logic        wr        = 1'b0;
	logic        rd        = 1'b0;
	logic [31:0] addr      = 32'h0;
	logic [31:0] wdata     = 32'h0;
	logic [31:0] rdata;
	logic [31:0] d;
	logic [31:0] x;
	logic [15:0] lf        = 16'h3126;
	tlie_flags_t want      = 17'h0;
	tlie_flags_t src;
	tlie_flags_t irq;
	tlie_flags_t en        = 17'h0;
	int          error_cnt = 0;
	int          n_checks  = 0;
	int          cyc       = 0;

	always #25 clk = ~clk;

	tlie_enable_bank tlie_enable_bank_i (
		.core_clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .src_i(src), .irq_o(irq));
	tlie_src_model tlie_src_model_i (.core_clk_i(clk), .sys_rst_i(rst),
		.want_i(want), .src_o(src));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic rnd(output logic [31:0] v);
		lf = lfsr_next(lf);
		v[15:0] = lf;
		lf = lfsr_next(lf);
		v[31:16] = lf;
	endtask
	function automatic tlie_flags_t exp_en(input tlie_flags_t e,
		input logic [31:0] a, input logic [31:0] dv);
		if (a === SET_A) return e | dv[16:0];
		if (a === CLR_A) return e & ~dv[16:0];
		return e;
	endfunction
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] dv);
		@(posedge clk);
		addr <= a;
		wdata <= dv;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		en = exp_en(en, a, dv);
	endtask
	function automatic logic [31:0] map_addr(input logic [1:0] s);
		if (s == 2'h0) return UNMAPPED_ADDR;
		return s[0] ? SET_A : CLR_A;
	endfunction
	task automatic wr_rd(input logic [31:0] aw, input logic [31:0] dv,
		input logic [31:0] ar);
		@(posedge clk);
		addr <= aw;
		wdata <= dv;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		addr <= ar;
		rd <= 1'b1;
		en = exp_en(en, aw, dv);
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata back to back", {15'h0, en}, rdata);
	endtask
	task automatic rd_reg(input logic [31:0] a);
		logic [31:0] e;
		e = (a === IRQ_ENABLE_SET_ADDR || a === IRQ_ENABLE_CLEAR_ADDR)
			? {15'h0, en} : 32'h0;
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
		@(posedge clk);
		#1 chk("rdata idle", 32'h0, rdata);
	endtask
	task automatic irq_chk(input tlie_flags_t v);
		@(posedge clk);
		want <= v;
		repeat (3) @(posedge clk);
		#1 chk("irq", {15'h0, v & en}, {15'h0, irq});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd_reg(SET_A);
		$display("reset value done");
		for (int b = 0; b < 17; b++) begin
			d = 32'h1 << b;
			wr_reg(SET_A, d);
			rd_reg(SET_A);
			irq_chk(17'h1ffff);
			wr_reg(CLR_A, d);
			rd_reg(CLR_A);
		end
		$display("single source walk done");
		wr_rd(SET_A, 32'hfffe0000, SET_A);
		wr_rd(SET_A, 32'h0001ffff, CLR_A);
		wr_rd(CLR_A, 32'h0000a5a5, SET_A);
		wr_rd(CLR_A, 32'hffffffff, CLR_A);
		$display("back to back corners done");
		for (int i = 0; i < 60; i++) begin
			rnd(d);
			rnd(x);
			wr_reg(map_addr(x[1:0]), d);
			rd_reg(map_addr({1'b1, x[2]}));
			irq_chk(d[16:0] ^ x[16:0]);
		end
		rd_reg(UNMAPPED_ADDR);
		$display("random access mix done");
		wr_reg(SET_A, 32'h0001ffff);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		en = ENABLE_RESET;
		rd_reg(SET_A);
		irq_chk(17'h1ffff);
		$display("mid-run reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
